//--- serial_nand_pkg.sv
// shared constants, lane modes and lane helpers for both ends of the serial nand link
// assumes a single 250 mhz system clock on both ends
package serial_nand_pkg;

  typedef enum logic [1:0] {
    LANE_SINGLE = 2'h0,
    LANE_DUAL = 2'h1,
    LANE_QUAD = 2'h2
  } lane_mode_t;

  localparam int CLK_PERIOD_NS = 4;
  localparam int SLEEP_IDLE_NS = 1000;
  localparam int SLEEP_IDLE_CYC_INT = (SLEEP_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SLEEP_IDLE_CYCLES = 8'(SLEEP_IDLE_CYC_INT);
  localparam int SCLK_HALF_NS = 32;
  localparam logic [3:0] SCLK_HALF_CYCLES = 4'(SCLK_HALF_NS / CLK_PERIOD_NS);

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [2:0] SYNC_HIGH_RESET = 3'h7;
  localparam logic [2:0] BLOCK_PROTECT_RESET = 3'h0;

  localparam int PAGE_LSB = 0;
  localparam int PAGE_W = 6;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_W = 10;
  localparam logic [11:0] MAIN_BYTES = 12'h800;
  localparam logic [11:0] PAGE_BYTES = 12'h840;

  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 8;

  localparam logic [3:0] MASK_NONE = 4'h0;
  localparam logic [3:0] MASK_SINGLE_HOST = 4'h1;
  localparam logic [3:0] MASK_SINGLE_DEV = 4'h2;
  localparam logic [3:0] MASK_DUAL = 4'h3;
  localparam logic [3:0] MASK_QUAD = 4'hf;
  localparam logic [3:0] MASK_PINS = 4'hc;

  function automatic logic [3:0] lane_bits(lane_mode_t m);
    case (m)
      LANE_DUAL: lane_bits = 4'h2;
      LANE_QUAD: lane_bits = 4'h4;
      default: lane_bits = 4'h1;
    endcase
  endfunction

  // msb first; in dual and quad the highest lane carries the highest bit
  function automatic logic [7:0] shift_in_chunk(logic [7:0] s, logic [3:0] l, logic one,
                                                lane_mode_t m);
    case (m)
      LANE_DUAL: shift_in_chunk = {s[5:0], l[1:0]};
      LANE_QUAD: shift_in_chunk = {s[3:0], l};
      default: shift_in_chunk = {s[6:0], one};
    endcase
  endfunction

  // single mode puts the bit on lanes 0 and 1; the enables pick the lane
  function automatic logic [3:0] out_chunk(logic [7:0] b, lane_mode_t m);
    case (m)
      LANE_DUAL: out_chunk = {2'h0, b[7:6]};
      LANE_QUAD: out_chunk = b[7:4];
      default: out_chunk = {2'h0, b[7], b[7]};
    endcase
  endfunction

  function automatic logic [7:0] shift_next(logic [7:0] b, lane_mode_t m);
    shift_next = 8'(b << lane_bits(m));
  endfunction

endpackage

//--- serial_nand_link.sv
// four-lane serial nand link with clock and select, one modport per end
// assumes undriven lanes are pulled high, as the pins float to a pull-up
interface serial_nand_link;
  logic sclk;
  logic cs_n;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] lane;

  assign lane = (dev_o & dev_oe) | (host_o & host_oe & ~dev_oe) | ~(dev_oe | host_oe);

  modport host (
    output sclk,
    output cs_n,
    output host_o,
    output host_oe,
    input lane
  );

  modport device (
    input sclk,
    input cs_n,
    input lane,
    output dev_o,
    output dev_oe
  );
endinterface

//--- byte_fifo.sv
// synchronous fifo with valid and ready on both sides
// assumes depth is a power of two and one clock for both sides
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
  } fifo_state_t;

  fifo_state_t s_reg;
  fifo_state_t s_next;
  logic push;
  logic pop;

  assign in_ready = s_reg.count != (AW + 1)'(DEPTH);
  assign out_valid = s_reg.count != '0;
  assign out_data = s_reg.mem[s_reg.rd];

  always_comb
  begin
    s_next = s_reg;
    push = in_valid & in_ready;
    pop = out_valid & out_ready;
    if (push)
    begin
      s_next.mem[s_reg.wr] = in_data;
      s_next.wr = AW'(s_reg.wr + 1'b1);
    end
    if (pop)
    begin
      s_next.rd = AW'(s_reg.rd + 1'b1);
    end
    s_next.count = (AW + 1)'(s_reg.count + push - pop);
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end
endmodule

//--- nand_device_end.sv
// device end of the serial nand link: lanes, hold, sleep, write protect, address map
// assumes link pins arrive asynchronously and are sampled on clk; command decode sits outside
// Functional notes
// - works with host clock modes 0 and 3
// - sample on rising, drive on falling
// - active only with select low, else lanes released
// - dual commands use lanes 0 and 1 both ways
// - quad commands add protect and hold pins as lanes
// - hold pauses serial traffic, internal work continues
// - hold starts at hold fall with clock low
// - with clock high, hold waits for falling edge
// - locked and protect low rejects block-protect writes
// - after sleep, first command only wakes, discarded
// - sleep is off after reset
// - row bits five to zero pick page
// - row bits fifteen to six pick block
// - column address valid only up to 2111
// - page has 2048 main plus 64 spare
// - 1024 blocks of 64 pages
module nand_device_end (
  input wire logic clk,
  input wire logic rstn,
  serial_nand_link.device link,
  input wire serial_nand_pkg::lane_mode_t lane_mode,
  input wire logic dir_out,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_overrun,
  input wire logic overrun_clear,
  output logic frame_active,
  output logic holding,
  input wire logic sleep_enable,
  output logic asleep,
  output logic discarding,
  input wire logic lock_write_disable,
  input wire logic bp_write_valid,
  input wire logic [2:0] bp_write_data,
  output logic [2:0] block_protect,
  output logic bp_write_rejected,
  input wire logic [15:0] row_address,
  input wire logic [11:0] column_address,
  output logic [5:0] page_index,
  output logic [9:0] block_index,
  output logic column_valid,
  output logic column_spare
);

  typedef struct packed {
    logic [2:0] sclk_s;
    logic [2:0] cs_s;
    logic [3:0] lane_s0;
    logic [3:0] lane_s1;
    logic hold_prev;
    logic holding;
    logic hold_pending;
    logic [7:0] shift_in;
    logic [3:0] bit_cnt;
    logic [7:0] shift_out;
    logic [3:0] out_cnt;
    logic [3:0] out_val;
    logic [3:0] out_en;
    logic sleep_en;
    logic asleep;
    logic swallow;
    logic [7:0] idle_cnt;
    logic overrun;
    logic [2:0] bp;
    logic bp_reject;
    logic [5:0] page;
    logic [9:0] block;
    logic col_ok;
    logic col_spare;
  } dev_state_t;

  dev_state_t s_reg;
  dev_state_t s_next;
  logic rise;
  logic fall;
  logic active;
  logic cs_fall;
  logic cs_rise;
  logic quad;
  logic hold_pin;
  logic take;
  logic wp_low;
  logic [3:0] bits;
  logic [3:0] cnt_sum;
  logic [7:0] byte_in;
  logic [7:0] byte_src;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_in_data;

  byte_fifo #(
    .WIDTH(serial_nand_pkg::FIFO_WIDTH),
    .DEPTH(serial_nand_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clk(clk),
    .rstn(rstn),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in_data),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data)
  );

  always_comb
  begin
    s_next = s_reg;
    s_next.sclk_s = {s_reg.sclk_s[1:0], link.sclk};
    s_next.cs_s = {s_reg.cs_s[1:0], link.cs_n};
    s_next.lane_s0 = link.lane;
    s_next.lane_s1 = s_reg.lane_s0;
    // same edge rules for mode 0 and mode 3
    rise = s_reg.sclk_s[1] & ~s_reg.sclk_s[2];
    fall = s_reg.sclk_s[2] & ~s_reg.sclk_s[1];
    active = ~s_reg.cs_s[1];
    cs_fall = s_reg.cs_s[2] & ~s_reg.cs_s[1];
    cs_rise = s_reg.cs_s[1] & ~s_reg.cs_s[2];
    quad = lane_mode == serial_nand_pkg::LANE_QUAD;
    bits = serial_nand_pkg::lane_bits(lane_mode);
    fifo_in_valid = 1'b0;
    fifo_in_data = s_reg.shift_in;
    tx_ready = 1'b0;
    byte_in = serial_nand_pkg::shift_in_chunk(s_reg.shift_in, s_reg.lane_s1,
                                              s_reg.lane_s1[0], lane_mode);
    cnt_sum = s_reg.bit_cnt + bits;
    byte_src = s_reg.shift_out;

    // sleep after a clock pause, wake swallows the frame
    s_next.sleep_en = sleep_enable;
    if (cs_rise)
    begin
      s_next.swallow = 1'b0;
    end
    if (rise | fall)
    begin
      s_next.idle_cnt = '0;
      if (s_reg.asleep)
      begin
        s_next.asleep = 1'b0;
        s_next.swallow = 1'b1;
      end
    end
    else if (s_reg.idle_cnt != serial_nand_pkg::SLEEP_IDLE_CYCLES)
    begin
      s_next.idle_cnt = s_reg.idle_cnt + 8'h01;
    end
    else if (s_reg.sleep_en)
    begin
      s_next.asleep = 1'b1;
    end

    // hold pin is lane 3 unless quad takes it over
    hold_pin = s_reg.lane_s1[3];
    s_next.hold_prev = quad | hold_pin;
    if (quad || (~s_reg.hold_prev & hold_pin))
    begin
      s_next.holding = 1'b0;
      s_next.hold_pending = 1'b0;
    end
    else if (s_reg.hold_prev & ~hold_pin)
    begin
      if (s_reg.sclk_s[1])
      begin
        s_next.hold_pending = 1'b1;
      end
      else
      begin
        s_next.holding = 1'b1;
      end
    end
    else if (s_reg.hold_pending && fall)
    begin
      s_next.holding = 1'b1;
      s_next.hold_pending = 1'b0;
    end

    // clock edges count only while selected and not held
    take = active & (~s_reg.holding | ~s_next.holding);
    if (cs_fall)
    begin
      s_next.bit_cnt = '0;
      s_next.out_cnt = '0;
    end
    else if (take && rise && !dir_out)
    begin
      s_next.shift_in = byte_in;
      s_next.bit_cnt = cnt_sum;
      if (cnt_sum == serial_nand_pkg::BYTE_BITS)
      begin
        s_next.bit_cnt = '0;
        fifo_in_data = byte_in;
        fifo_in_valid = ~s_reg.swallow;
      end
    end
    else if (take && fall && dir_out)
    begin
      if (s_reg.out_cnt == '0)
      begin
        byte_src = tx_valid ? tx_data : serial_nand_pkg::FILL_BYTE;
        tx_ready = tx_valid;
      end
      s_next.out_val = serial_nand_pkg::out_chunk(byte_src, lane_mode);
      s_next.shift_out = serial_nand_pkg::shift_next(byte_src, lane_mode);
      s_next.out_cnt = ((s_reg.out_cnt == '0) ? serial_nand_pkg::BYTE_BITS : s_reg.out_cnt)
                       - bits;
    end

    // lanes released unless selected, driving, not held and not swallowing a wake frame
    s_next.out_en = serial_nand_pkg::MASK_NONE;
    if (active && dir_out && !s_next.holding && !s_reg.swallow)
    begin
      case (lane_mode)
        serial_nand_pkg::LANE_DUAL: s_next.out_en = serial_nand_pkg::MASK_DUAL;
        serial_nand_pkg::LANE_QUAD: s_next.out_en = serial_nand_pkg::MASK_QUAD;
        default: s_next.out_en = serial_nand_pkg::MASK_SINGLE_DEV;
      endcase
    end

    if (overrun_clear)
    begin
      s_next.overrun = 1'b0;
    end
    if (fifo_in_valid && !fifo_in_ready)
    begin
      s_next.overrun = 1'b1;
    end

    // protect pin is lane 2 outside quad
    wp_low = ~quad & ~s_reg.lane_s1[2];
    s_next.bp_reject = 1'b0;
    if (bp_write_valid)
    begin
      if (lock_write_disable && wp_low)
      begin
        s_next.bp_reject = 1'b1;
      end
      else
      begin
        s_next.bp = bp_write_data;
      end
    end

    // 1024 blocks of 64 pages, 2048 plus 64 bytes a page
    s_next.page = row_address[serial_nand_pkg::PAGE_LSB +: serial_nand_pkg::PAGE_W];
    s_next.block = row_address[serial_nand_pkg::BLOCK_LSB +: serial_nand_pkg::BLOCK_W];
    s_next.col_ok = column_address < serial_nand_pkg::PAGE_BYTES;
    s_next.col_spare = s_next.col_ok && column_address >= serial_nand_pkg::MAIN_BYTES;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.sclk_s <= serial_nand_pkg::SYNC_HIGH_RESET;
      s_reg.cs_s <= serial_nand_pkg::SYNC_HIGH_RESET;
      s_reg.hold_prev <= 1'b1;
      s_reg.bp <= serial_nand_pkg::BLOCK_PROTECT_RESET;
      s_reg.sleep_en <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign link.dev_o = s_reg.out_val;
  assign link.dev_oe = s_reg.out_en;
  assign rx_overrun = s_reg.overrun;
  assign frame_active = ~s_reg.cs_s[2];
  assign holding = s_reg.holding;
  assign asleep = s_reg.asleep;
  assign discarding = s_reg.swallow;
  assign block_protect = s_reg.bp;
  assign bp_write_rejected = s_reg.bp_reject;
  assign page_index = s_reg.page;
  assign block_index = s_reg.block;
  assign column_valid = s_reg.col_ok;
  assign column_spare = s_reg.col_spare;
endmodule

//--- nand_host_end.sv
// host end of the serial nand link: clock divider, select, lane shifting
// assumes the device answers within five clk cycles of a falling link clock edge
module nand_host_end (
  input wire logic clk,
  input wire logic rstn,
  serial_nand_link.host link,
  input wire logic cpol_mode3,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_data,
  input wire serial_nand_pkg::lane_mode_t cmd_mode,
  input wire logic cmd_read,
  input wire logic cmd_last,
  input wire logic hold_level_n,
  input wire logic wp_level_n,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic busy
);

  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_LOW = 2'h1,
    H_HIGH = 2'h2,
    H_END = 2'h3
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t fsm;
    logic [3:0] div;
    logic sclk;
    logic cs_n;
    logic [7:0] shift_out;
    logic [7:0] shift_in;
    logic [3:0] bit_cnt;
    serial_nand_pkg::lane_mode_t mode;
    logic read;
    logic last;
    logic [3:0] lane_s0;
    logic [3:0] lane_s1;
    logic [3:0] o;
    logic [3:0] oe;
    logic [7:0] rd;
    logic rd_valid;
  } host_state_t;

  host_state_t s_reg;
  host_state_t s_next;
  logic [3:0] cnt_sum;
  logic half_done;

  always_comb
  begin
    s_next = s_reg;
    s_next.lane_s0 = link.lane;
    s_next.lane_s1 = s_reg.lane_s0;
    s_next.rd_valid = 1'b0;
    cmd_ready = 1'b0;
    half_done = s_reg.div == serial_nand_pkg::SCLK_HALF_CYCLES;
    cnt_sum = s_reg.bit_cnt + serial_nand_pkg::lane_bits(s_reg.mode);
    if (!half_done)
    begin
      s_next.div = s_reg.div + 4'h1;
    end
    unique case (s_reg.fsm)
      H_IDLE:
      begin
        s_next.sclk = cpol_mode3;
        s_next.cs_n = 1'b1;
      end
      H_LOW:
      begin
        // hold pauses the clock while low
        if (half_done && hold_level_n)
        begin
          s_next.sclk = 1'b1;
          s_next.fsm = H_HIGH;
          s_next.div = '0;
          s_next.bit_cnt = cnt_sum;
          s_next.shift_in = serial_nand_pkg::shift_in_chunk(s_reg.shift_in, s_reg.lane_s1,
                                                            s_reg.lane_s1[1], s_reg.mode);
          if (s_reg.read && cnt_sum == serial_nand_pkg::BYTE_BITS)
          begin
            s_next.rd = s_next.shift_in;
            s_next.rd_valid = 1'b1;
          end
        end
      end
      H_HIGH:
      begin
        if (half_done && s_reg.bit_cnt != serial_nand_pkg::BYTE_BITS)
        begin
          s_next.sclk = 1'b0;
          s_next.fsm = H_LOW;
          s_next.div = '0;
          s_next.o = serial_nand_pkg::out_chunk(s_reg.shift_out, s_reg.mode);
          s_next.shift_out = serial_nand_pkg::shift_next(s_reg.shift_out, s_reg.mode);
        end
        else if (half_done && s_reg.last)
        begin
          s_next.sclk = cpol_mode3;
          s_next.fsm = H_END;
          s_next.div = '0;
        end
      end
      H_END:
      begin
        if (half_done)
        begin
          s_next.cs_n = 1'b1;
          s_next.fsm = H_IDLE;
          s_next.div = '0;
        end
      end
    endcase
    // a new byte starts a frame or continues one at a byte boundary
    if (half_done && cmd_valid && (s_reg.fsm == H_IDLE ||
        (s_reg.fsm == H_HIGH && s_reg.bit_cnt == serial_nand_pkg::BYTE_BITS && !s_reg.last)))
    begin
      cmd_ready = 1'b1;
      s_next.cs_n = 1'b0;
      s_next.sclk = 1'b0;
      s_next.fsm = H_LOW;
      s_next.div = '0;
      s_next.bit_cnt = '0;
      s_next.mode = cmd_mode;
      s_next.read = cmd_read;
      s_next.last = cmd_last;
      s_next.o = serial_nand_pkg::out_chunk(cmd_data, cmd_mode);
      s_next.shift_out = serial_nand_pkg::shift_next(cmd_data, cmd_mode);
    end
    // protect and hold pins driven unless quad uses them as data
    s_next.o[3:2] = (s_next.mode == serial_nand_pkg::LANE_QUAD) ? s_next.o[3:2]
                    : {hold_level_n, wp_level_n};
    s_next.oe = serial_nand_pkg::MASK_PINS;
    if (s_next.cs_n || s_next.read)
    begin
      s_next.oe = (s_next.mode == serial_nand_pkg::LANE_QUAD) ? serial_nand_pkg::MASK_NONE
                  : serial_nand_pkg::MASK_PINS;
    end
    else
    begin
      case (s_next.mode)
        serial_nand_pkg::LANE_DUAL: s_next.oe = serial_nand_pkg::MASK_DUAL | s_next.oe;
        serial_nand_pkg::LANE_QUAD: s_next.oe = serial_nand_pkg::MASK_QUAD;
        default: s_next.oe = serial_nand_pkg::MASK_SINGLE_HOST | s_next.oe;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      s_reg <= '0;
      s_reg.cs_n <= 1'b1;
      s_reg.o <= serial_nand_pkg::MASK_PINS;
      s_reg.oe <= serial_nand_pkg::MASK_PINS;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign link.sclk = s_reg.sclk;
  assign link.cs_n = s_reg.cs_n;
  assign link.host_o = s_reg.o;
  assign link.host_oe = s_reg.oe;
  assign rd_data = s_reg.rd;
  assign rd_valid = s_reg.rd_valid;
  assign busy = s_reg.fsm != H_IDLE;
endmodule

//--- serial_nand_link_assertions.sv
// timing checks on the wires of the serial nand link
// assumes both ends share clk and rstn, instantiated beside the link
module serial_nand_link_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_o,
  input wire logic [3:0] host_oe,
  input wire logic [3:0] dev_o,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] lane
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence sclk_edge;
    $changed(sclk);
  endsequence
  sequence select_open;
    $fell(cs_n);
  endsequence
  sequence select_close;
    $rose(cs_n);
  endsequence
  sequence hold_low;
    !cs_n && host_oe[3] && !lane[3] && !sclk;
  endsequence
  a_clk_half_period: assert property (sclk_edge |=> $stable(sclk) [*7])
    else $error("link clock edges closer than half a period");
  a_select_setup: assert property (select_open |=> $stable(sclk) [*7])
    else $error("link clock moved too soon after select");
  a_close_clk_idle: assert property (select_close |-> $stable(sclk) && $past(sclk, 4) == sclk)
    else $error("link clock not idle at deselect");
  a_select_gap: assert property (select_close |=> cs_n [*8])
    else $error("select gap too short");
  a_idle_released: assert property (cs_n [*8] |-> dev_oe == 4'h0)
    else $error("device drives lanes while deselected");
  a_dev_low_phase: assert property ($changed(dev_o) && !cs_n |-> !sclk && !$past(sclk, 2))
    else $error("device data changed outside low phase");
  a_host_low_phase: assert property ($changed(host_o[1:0]) && !cs_n |-> !sclk)
    else $error("host data changed outside low phase");
  a_turn_low_phase: assert property ($changed(dev_oe) && !cs_n |-> !sclk)
    else $error("lane direction changed outside low phase");
  c_hold_seen: cover property (hold_low [*8]);
endmodule

//--- serial_nand_host_interface_tb.sv
// bench joining host end and device end over one link
// assumes package, link, fifo and both ends compiled first
module serial_nand_host_interface_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, cpol_mode3, cmd_valid, cmd_ready, cmd_read, cmd_last, hold_level_n;
  logic wp_level_n, rd_valid, busy, dir_out, rx_valid, rx_ready, tx_valid, tx_ready;
  logic rx_overrun, overrun_clear, frame_active, holding, sleep_enable, asleep, discarding;
  logic lock_write_disable, bp_write_valid, bp_write_rejected, column_valid, column_spare;
  logic sclk_d;
  logic [7:0] cmd_data, rd_data, rx_data, tx_data;
  logic [2:0] bp_write_data, block_protect;
  logic [15:0] row_address;
  logic [11:0] column_address;
  logic [5:0] page_index;
  logic [9:0] block_index;
  serial_nand_pkg::lane_mode_t cmd_mode, lane_mode;
  logic [7:0] rx_q[$];
  logic [7:0] rd_q[$];
  int errors, checks_done, rises;
  serial_nand_link link();
  nand_host_end u_nand_host_end (
    .clk, .rstn, .link(link), .cpol_mode3, .cmd_valid, .cmd_ready, .cmd_data, .cmd_mode,
    .cmd_read, .cmd_last, .hold_level_n, .wp_level_n, .rd_data, .rd_valid, .busy
  );
  nand_device_end u_nand_device_end (
    .clk, .rstn, .link(link), .lane_mode, .dir_out, .rx_data, .rx_valid, .rx_ready, .tx_data,
    .tx_valid, .tx_ready, .rx_overrun, .overrun_clear, .frame_active, .holding, .sleep_enable,
    .asleep, .discarding, .lock_write_disable, .bp_write_valid, .bp_write_data,
    .block_protect, .bp_write_rejected, .row_address, .column_address, .page_index,
    .block_index, .column_valid, .column_spare
  );
  serial_nand_link_assertions u_chk (
    .clk(clk), .rstn(rstn), .sclk(link.sclk), .cs_n(link.cs_n), .host_o(link.host_o),
    .host_oe(link.host_oe), .dev_o(link.dev_o), .dev_oe(link.dev_oe), .lane(link.lane)
  );
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // wire watch, stream capture, read turnaround
  always @(posedge clk)
  begin
    sclk_d <= link.sclk;
    if (link.sclk && !sclk_d && !link.cs_n) rises <= rises + 1;
    if (rx_valid && rx_ready) rx_q.push_back(rx_data);
    if (rd_valid) rd_q.push_back(rd_data);
    if (link.cs_n) dir_out <= 1'b0;
    if (tx_ready) tx_valid <= 1'b0;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic give_up();
    errors++;
    $display("[ERR] %0t wait bound used up", $time);
    complete_run();
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic put(input logic [7:0] d, input serial_nand_pkg::lane_mode_t m, input logic rd,
                     input logic last);
    int n;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_data <= d;
    cmd_mode <= m;
    lane_mode <= m;
    cmd_read <= rd;
    cmd_last <= last;
    for (n = 0; n < 4000; n++)
    begin
      @(posedge clk);
      if (cmd_ready) break;
    end
    if (n == 4000) give_up();
    cmd_valid <= 1'b0;
  endtask
  task automatic wait_idle();
    int n;
    for (n = 0; n < 4000; n++)
    begin
      @(posedge clk);
      if (!busy && link.cs_n) break;
    end
    if (n == 4000) give_up();
    cyc(4);
  endtask
  task automatic t_map();
    logic [15:0] r;
    logic [11:0] cols[4];
    cols = '{12'h7ff, 12'h800, 12'h83f, 12'h840};
    for (int i = 0; i < 4; i++)
    begin
      r = 16'hffff >> (i * 5);
      row_address <= r;
      column_address <= cols[i];
      cyc(3);
      chk(page_index, r % 64);
      chk(block_index, r / 64);
      chk(column_valid, cols[i] < 12'h840);
      chk(column_spare, cols[i] >= 12'h800 && cols[i] < 12'h840);
    end
  endtask
  task automatic t_sleep();
    for (int s = 0; s < 2; s++)
    begin
      sleep_enable <= s[0];
      cyc(300);
      chk(asleep, s[0]);
      rx_q.delete();
      put(8'h5a, serial_nand_pkg::LANE_SINGLE, 1'b0, 1'b1);
      cyc(40);
      chk(discarding, s[0]);
      wait_idle();
      chk(rx_q.size(), 1 - s);
    end
    rx_q.delete();
    put(8'ha5, serial_nand_pkg::LANE_SINGLE, 1'b0, 1'b1);
    wait_idle();
    chk(rx_q[0], 8'ha5);
    sleep_enable <= 1'b0;
  endtask
  task automatic t_lanes();
    logic [7:0] d;
    int r0;
    for (int c = 0; c < 2; c++)
      for (int m = 0; m < 3; m++)
      begin
        d = 8'h3c + 8'(c * 3 + m);
        cpol_mode3 <= c[0];
        cyc(10);
        rx_q.delete();
        rd_q.delete();
        r0 = rises;
        put(d, serial_nand_pkg::lane_mode_t'(m), 1'b0, 1'b0);
        put(8'h00, serial_nand_pkg::lane_mode_t'(m), 1'b1, 1'b1);
        dir_out <= 1'b1;
        tx_data <= ~d;
        tx_valid <= 1'b1;
        wait_idle();
        chk(rx_q[0], d);
        chk(rd_q[0], {8'h00, ~d});
        chk(tx_valid, 1'b0);
        chk(rises - r0, 16 >> m);
        chk(link.dev_oe, 4'h0);
        chk(frame_active, 1'b0);
      end
  endtask
  task automatic t_hold(input logic hi);
    int n;
    int r0;
    cpol_mode3 <= 1'b0;
    cyc(10);
    rx_q.delete();
    put(8'h96 ^ 8'(hi), serial_nand_pkg::LANE_SINGLE, 1'b0, 1'b1);
    cyc(20);
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (link.sclk != sclk_d && link.sclk == hi) break;
    end
    hold_level_n <= 1'b0;
    cyc(5);
    if (hi) chk(holding, 1'b0);
    cyc(9);
    chk(holding, 1'b1);
    r0 = rises;
    cyc(40);
    chk(rises - r0, 0);
    chk(link.dev_oe, 4'h0);
    hold_level_n <= 1'b1;
    wait_idle();
    chk(rx_q[0], 8'h96 ^ 8'(hi));
  endtask
  task automatic t_bp();
    logic [8:0] tbl[3];
    // lock, protect level, data, expected bits, expected refusal
    tbl = '{9'h151, 9'h1a4, 9'h07e};
    lane_mode <= serial_nand_pkg::LANE_SINGLE;
    foreach (tbl[i])
    begin
      lock_write_disable <= tbl[i][8];
      wp_level_n <= tbl[i][7];
      bp_write_data <= tbl[i][6:4];
      cyc(8);
      bp_write_valid <= 1'b1;
      @(posedge clk);
      bp_write_valid <= 1'b0;
      @(posedge clk);
      chk(bp_write_rejected, tbl[i][0]);
      chk(block_protect, tbl[i][3:1]);
    end
    wp_level_n <= 1'b1;
  endtask
  task automatic t_fifo();
    rx_ready <= 1'b0;
    rx_q.delete();
    for (int i = 0; i < 9; i++)
      put(8'h10 + 8'(i), serial_nand_pkg::LANE_QUAD, 1'b0, i == 8);
    wait_idle();
    chk(rx_overrun, 1'b1);
    rx_ready <= 1'b1;
    cyc(20);
    chk(rx_q.size(), 8);
    foreach (rx_q[i]) chk(rx_q[i], 8'h10 + 8'(i));
    overrun_clear <= 1'b1;
    @(posedge clk);
    overrun_clear <= 1'b0;
    cyc(2);
    chk(rx_overrun, 1'b0);
  endtask
  initial
  begin
    rstn = 1'b0;
    {cpol_mode3, cmd_valid, cmd_read, cmd_last, dir_out, tx_valid, overrun_clear} = 7'h00;
    {sleep_enable, lock_write_disable, bp_write_valid, sclk_d} = 4'h0;
    {hold_level_n, wp_level_n, rx_ready} = 3'h7;
    cmd_data = 8'h00;
    tx_data = 8'h00;
    bp_write_data = 3'h0;
    row_address = 16'h0000;
    column_address = 12'h000;
    cmd_mode = serial_nand_pkg::LANE_SINGLE;
    lane_mode = serial_nand_pkg::LANE_SINGLE;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    cyc(12);
    t_map();
    t_sleep();
    t_lanes();
    t_hold(1'b0);
    t_hold(1'b1);
    t_bp();
    t_fifo();
    complete_run();
  end
endmodule
